// ==== rtl/lso_map.vh ====
/*
 * register offsets, field positions, reset values and timing counts of the
 * limit switch output controller.
 * assumes: included by its bare name from the design file; definitions only.
 */
`ifndef LSO_MAP_VH
`define LSO_MAP_VH

// byte offsets on the register bus (8-bit address)
`define LSO_ADDR_CTRL      8'h00
`define LSO_ADDR_ON_VALUE  8'h04
`define LSO_ADDR_OFF_VALUE 8'h08
`define LSO_ADDR_ON_DELAY  8'h0C
`define LSO_ADDR_OFF_DELAY 8'h10
`define LSO_ADDR_STATUS    8'h14
`define LSO_ADDR_INT_STAT  8'h18
`define LSO_ADDR_INT_CLR   8'h1C
`define LSO_ADDR_INT_EN    8'h20

// control register fields
`define LSO_CTRL_FUNC_LSB  0
`define LSO_CTRL_FUNC_MSB  2
`define LSO_CTRL_FAIL_LSB  3
`define LSO_CTRL_FAIL_MSB  4
`define LSO_CTRL_INV_BIT   5
`define LSO_CTRL_DIAG_LSB  6
`define LSO_CTRL_DIAG_MSB  7

// output function codes
`define LSO_FUNC_OFF       3'h0
`define LSO_FUNC_ON        3'h1
`define LSO_FUNC_DIAG      3'h2
`define LSO_FUNC_LIMIT     3'h3
`define LSO_FUNC_DIGITAL   3'h4

// failure mode codes
`define LSO_FAIL_ACTUAL    2'h0
`define LSO_FAIL_OPEN      2'h1
`define LSO_FAIL_CLOSED    2'h2

// diagnostic event class codes
`define LSO_DIAG_ALARM     2'h0
`define LSO_DIAG_ALM_WARN  2'h1
`define LSO_DIAG_WARNING   2'h2

// reset values
`define LSO_RST_FUNC       3'h0
`define LSO_RST_FAIL       2'h1
`define LSO_RST_INV        1'h0
`define LSO_RST_DIAG       2'h0
`define LSO_RST_VALUE      32'h00000000
`define LSO_RST_DELAY      11'h000

// delays are entered in tenths of a second, 0 to 1000 (0.0 to 100.0 s)
`define LSO_DELAY_MAX      11'h3E8
`define LSO_TICK_NS        100000000
`define LSO_CLK_PERIOD_NS  40
`define LSO_TICK_CYCLES    (`LSO_TICK_NS / `LSO_CLK_PERIOD_NS)

// interrupt status bits
`define LSO_INT_CLOSED     0
`define LSO_INT_OPENED     1
`define LSO_INT_ERROR      2

// bus responses
`define LSO_RESP_OKAY      2'h0
`define LSO_RESP_SLVERR    2'h2

`endif

// ==== rtl/lso_switch_output.v ====
/*
 * limit switch output controller: one open/closed output driven by a
 * function selection, a two-threshold float hysteresis with on/off delays,
 * a failure override and inversion; registers over AXI4-Lite.
 * assumes: measured value, error and event inputs come from logic on the
 * same clock; measured value and thresholds are IEEE-754 single floats.
 */
// Added by the designer: the AXI4-Lite register port and the address map.
`include "lso_map.vh"
`default_nettype none

module lso_switch_output #(
   parameter TICK_CYCLES = `LSO_TICK_CYCLES   // clocks per 0.1 s delay step
) (
   // clock and reset
   input  wire        clock,
   input  wire        arst_n,
   // register bus, AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // process inputs
   input  wire [31:0] measValue,
   input  wire        errorPresent,
   input  wire        alarmEvent,
   input  wire        warningEvent,
   input  wire        digitalIn,
   // outputs
   output reg         switchClosed,
   output wire        irq
);

   // turn a float into an unsigned key that orders like the value; -0 -> +0
   function [31:0] sortKey;
      input [31:0] f;
      begin
         if (f[30:0] == 31'h00000000)
            sortKey = 32'h80000000;
         else if (f[31])
            sortKey = ~f;
         else
            sortKey = f ^ 32'h80000000;
      end
   endfunction
   // merge written bytes into an old word under the byte strobes
   function [31:0] mergeBytes;
      input [31:0] oldWord;
      input [31:0] newWord;
      input [3:0]  strb;
      integer i;
      begin
         mergeBytes = oldWord;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i])
               mergeBytes[i*8 +: 8] = newWord[i*8 +: 8];
         end
      end
   endfunction
   // clamp a written delay to 0..1000 tenths
   function [10:0] clampDelay;
      input [31:0] w;
      begin
         if (w > {21'h000000, `LSO_DELAY_MAX})
            clampDelay = `LSO_DELAY_MAX;
         else
            clampDelay = w[10:0];
      end
   endfunction
   localparam [22:0] TICK_LAST = TICK_CYCLES[22:0] - 23'h000001;   // last prescaler count
   reg  [1:0]  rstSync_reg;        // reset release synchroniser
   wire        rstN;               // synchronised reset, active low
   reg  [2:0]  funcSel_reg;        // output function
   reg  [1:0]  failMode_reg;       // state on error
   reg         invert_reg;         // output inversion
   reg  [1:0]  diagSel_reg;        // diagnostic event class
   reg  [31:0] onValue_reg;        // switch-on threshold
   reg  [31:0] offValue_reg;       // switch-off threshold
   reg  [10:0] onDelay_reg;        // switch-on delay, tenths of s
   reg  [10:0] offDelay_reg;       // switch-off delay, tenths of s
   reg         limitState_reg;     // limit comparator state, 1 = closed
   reg         pending_reg;        // delayed change under way
   reg         pendDir_reg;        // direction of pending change, 1 = close
   reg  [10:0] tenthsLeft_reg;     // remaining delay steps
   reg  [22:0] prescale_reg;       // cycles within one delay step
   reg  [2:0]  intStat_reg;        // sticky event bits
   reg  [2:0]  intEn_reg;          // event enables
   reg         errorPrev_reg;      // error level one cycle ago
   reg         awHeld_reg;         // write address taken
   reg  [7:0]  awAddr_reg;         // held write address
   reg         wHeld_reg;          // write data taken
   reg  [31:0] wData_reg;          // held write data
   reg  [3:0]  wStrb_reg;          // held byte strobes
   // comparison keys
   wire [31:0] measKey = sortKey(measValue);
   wire [31:0] onKey   = sortKey(onValue_reg);
   wire [31:0] offKey  = sortKey(offValue_reg);
   wire        onAbove = (onKey >= offKey);
   reg         closeCond;          // value asks for closed
   reg         openCond;           // value asks for open
   reg         diagHit;            // selected event class present
   reg         rawState;           // output before error and inversion
   reg         failState;          // output after error override
   wire        closeNow;           // final output state

   // reset release through two flip-flops
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n)
         rstSync_reg <= 2'h0;
      else
         rstSync_reg <= {rstSync_reg[0], 1'b1};
   end
   assign rstN = rstSync_reg[1];

   // hysteresis comparison of the measured value
   always @* begin
      if (onAbove) begin
         closeCond = (measKey > onKey);
         openCond  = (measKey < offKey);
      end else begin
         closeCond = (measKey < onKey);
         openCond  = (measKey > offKey);
      end
   end

   // limit state with delayed switching; band holds, vanished cause cancels
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         limitState_reg <= 1'b1;   // normally closed
         pending_reg    <= 1'b0;
         pendDir_reg    <= 1'b0;
         tenthsLeft_reg <= `LSO_RST_DELAY;
         prescale_reg   <= 23'h000000;
      end else if ((closeCond && !limitState_reg) || (openCond && limitState_reg)) begin
         if (!pending_reg || pendDir_reg != closeCond) begin
            // new request: load the delay of its direction
            pending_reg    <= 1'b1;
            pendDir_reg    <= closeCond;
            tenthsLeft_reg <= closeCond ? onDelay_reg : offDelay_reg;
            prescale_reg   <= 23'h000000;
         end else if (tenthsLeft_reg == 11'h000) begin
            // delay expired: take the new state
            limitState_reg <= pendDir_reg;
            pending_reg    <= 1'b0;
         end else if (prescale_reg == TICK_LAST) begin
            prescale_reg   <= 23'h000000;
            tenthsLeft_reg <= tenthsLeft_reg - 11'h001;
         end else begin
            prescale_reg   <= prescale_reg + 23'h000001;
         end
      end else begin
         // in band or already there: hold and drop any pending change
         pending_reg  <= 1'b0;
         prescale_reg <= 23'h000000;
      end
   end

   // diagnostic class selection and function multiplexer
   always @* begin
      case (diagSel_reg)
         `LSO_DIAG_ALARM:    diagHit = alarmEvent;
         `LSO_DIAG_ALM_WARN: diagHit = alarmEvent | warningEvent;
         `LSO_DIAG_WARNING:  diagHit = warningEvent;
         default:            diagHit = alarmEvent;
      endcase
      case (funcSel_reg)
         `LSO_FUNC_OFF:     rawState = 1'b0;
         `LSO_FUNC_ON:      rawState = 1'b1;
         `LSO_FUNC_DIAG:    rawState = ~diagHit;
         `LSO_FUNC_LIMIT:   rawState = limitState_reg;
         `LSO_FUNC_DIGITAL: rawState = digitalIn;
         default:           rawState = 1'b0;
      endcase
      failState = rawState;
      if (errorPresent && (funcSel_reg == `LSO_FUNC_LIMIT
                           || funcSel_reg == `LSO_FUNC_DIGITAL)) begin
         case (failMode_reg)
            `LSO_FAIL_OPEN:   failState = 1'b0;
            `LSO_FAIL_CLOSED: failState = 1'b1;
            default:          failState = rawState;
         endcase
      end
   end

   // inversion; cleared invert passes the state straight through
   assign closeNow = failState ^ invert_reg;

   // registered output, events and sticky interrupt bits (set wins clear)
   wire       intClr   = awHeld_reg && wHeld_reg && !s_axi_bvalid
                         && awAddr_reg == `LSO_ADDR_INT_CLR;
   wire [2:0] intEvent = {errorPresent & ~errorPrev_reg,
                          switchClosed & ~closeNow,
                          ~switchClosed & closeNow};
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         switchClosed  <= 1'b0;
         errorPrev_reg <= 1'b0;
         intStat_reg   <= 3'h0;
      end else begin
         switchClosed  <= closeNow;
         errorPrev_reg <= errorPresent;
         intStat_reg   <= (intStat_reg & ~({3{intClr}} & wData_reg[2:0])) | intEvent;
      end
   end
   assign irq = |(intStat_reg & intEn_reg);

   // write channel: address and data taken in either order, one at a time
   assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
   wire   doWrite       = awHeld_reg && wHeld_reg && !s_axi_bvalid;
   wire [31:0] ctrlWord = {24'h000000, diagSel_reg, invert_reg, failMode_reg, funcSel_reg};
   wire [31:0] ctrlNew  = mergeBytes(ctrlWord, wData_reg, wStrb_reg);

   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         awHeld_reg   <= 1'b0;
         awAddr_reg   <= 8'h00;
         wHeld_reg    <= 1'b0;
         wData_reg    <= 32'h00000000;
         wStrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `LSO_RESP_OKAY;
         funcSel_reg  <= `LSO_RST_FUNC;
         failMode_reg <= `LSO_RST_FAIL;
         invert_reg   <= `LSO_RST_INV;
         diagSel_reg  <= `LSO_RST_DIAG;
         onValue_reg  <= `LSO_RST_VALUE;
         offValue_reg <= `LSO_RST_VALUE;
         onDelay_reg  <= `LSO_RST_DELAY;
         offDelay_reg <= `LSO_RST_DELAY;
         intEn_reg    <= 3'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg   <= 1'b0;
            wHeld_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `LSO_RESP_OKAY;
            case (awAddr_reg)
               `LSO_ADDR_CTRL: begin
                  funcSel_reg  <= ctrlNew[`LSO_CTRL_FUNC_MSB:`LSO_CTRL_FUNC_LSB];
                  failMode_reg <= ctrlNew[`LSO_CTRL_FAIL_MSB:`LSO_CTRL_FAIL_LSB];
                  invert_reg   <= ctrlNew[`LSO_CTRL_INV_BIT];
                  diagSel_reg  <= ctrlNew[`LSO_CTRL_DIAG_MSB:`LSO_CTRL_DIAG_LSB];
               end
               `LSO_ADDR_ON_VALUE:
                  onValue_reg <= mergeBytes(onValue_reg, wData_reg, wStrb_reg);
               `LSO_ADDR_OFF_VALUE:
                  offValue_reg <= mergeBytes(offValue_reg, wData_reg, wStrb_reg);
               `LSO_ADDR_ON_DELAY:
                  onDelay_reg <= clampDelay(mergeBytes({21'h000000, onDelay_reg},
                                                       wData_reg, wStrb_reg));
               `LSO_ADDR_OFF_DELAY:
                  offDelay_reg <= clampDelay(mergeBytes({21'h000000, offDelay_reg},
                                                        wData_reg, wStrb_reg));
               `LSO_ADDR_INT_EN:
                  intEn_reg <= wStrb_reg[0] ? wData_reg[2:0] : intEn_reg;
               `LSO_ADDR_STATUS, `LSO_ADDR_INT_STAT, `LSO_ADDR_INT_CLR: ;
               default:
                  s_axi_bresp <= `LSO_RESP_SLVERR;   // unmapped address
            endcase
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read channel: one read at a time, data registered
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `LSO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `LSO_RESP_OKAY;
         case (s_axi_araddr)
            `LSO_ADDR_CTRL:      s_axi_rdata <= ctrlWord;
            `LSO_ADDR_ON_VALUE:  s_axi_rdata <= onValue_reg;
            `LSO_ADDR_OFF_VALUE: s_axi_rdata <= offValue_reg;
            `LSO_ADDR_ON_DELAY:  s_axi_rdata <= {21'h000000, onDelay_reg};
            `LSO_ADDR_OFF_DELAY: s_axi_rdata <= {21'h000000, offDelay_reg};
            // present switch state, limit state, pending flag
            `LSO_ADDR_STATUS:    s_axi_rdata <= {29'h00000000, pending_reg,
                                                 limitState_reg, switchClosed};
            `LSO_ADDR_INT_STAT:  s_axi_rdata <= {29'h00000000, intStat_reg};
            `LSO_ADDR_INT_CLR:   s_axi_rdata <= 32'h00000000;
            `LSO_ADDR_INT_EN:    s_axi_rdata <= {29'h00000000, intEn_reg};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `LSO_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== test/lso_checker.sv ====
/*
 * bus-side assertions for the limit switch output controller.
 * assumes: bound to lso_switch_output; one clock; arst_n active low.
 */
`default_nettype none
module lso_checker (
   // clock and reset
   input wire logic        clock,
   input wire logic        arst_n,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // address and data of a write taken at one edge
   sequence wrTake;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // response arrives exactly two edges later
   sequence wrAnswer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   write_answer_a: assert property (wrTake |=> wrAnswer)
      else $error("write response not two edges after the request");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while a response waits");
   next_write_a: assert property (s_axi_bvalid && s_axi_bready |=>
      s_axi_awready && s_axi_wready) else $error("write not open after response");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one edge after the request");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data waits");
   slverr_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
      s_axi_rdata == 32'h00000000) else $error("error read carries data");
   rvalid_fall_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
      else $error("read data withdrawn without handshake");
endmodule
`default_nettype wire

// ==== test/tb_lso_switch_output.sv ====
/*
 * self-checking bench for the limit switch output controller.
 * assumes: lso_checker compiled first; rtl/ on the include path.
 */
`include "lso_map.vh"
`default_nettype none
module tb_lso_switch_output;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 20000;   // cycle ceiling of the run
   // clock and reset
   logic        clock = 1'b0;
   logic        arst_n;
   // register bus
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, bResp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   // process side
   logic [31:0] measValue;
   logic        errorPresent, alarmEvent, warningEvent, digitalIn;
   logic        switchClosed, irq;
   // bookkeeping
   int          error_cnt = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          lateRdy = 0;       // edges before bready/rready rise

   lso_switch_output #(.TICK_CYCLES(4)) u_lso_switch_output (.*);

   always #20 clock = ~clock;

   // compare one value, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
   endtask
   // a bus wait that reached 50 edges counts as a mismatch here
   task automatic late(input int n);
      if (n >= 50) begin
         error_cnt++;
         $display("mismatch at %0t: bus answer missing", $time);
      end
   endtask
   task automatic outIs(input logic e);
      chk({31'h0, switchClosed}, {31'h0, e});
   endtask
   // one write; both halves offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= (lateRdy == 0);
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (n >= lateRdy && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
      bResp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      late(n);
   endtask
   // one read, compared against data and response
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= (lateRdy == 0);
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (n >= lateRdy && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, r});
      s_axi_rready <= 1'b0;
      late(n);
   endtask
   task automatic meas(input logic [31:0] v, input int n);
      measValue <= v;
      idle(n);
   endtask

   task automatic testReset();
      rdchk(`LSO_ADDR_CTRL, 32'h08, `LSO_RESP_OKAY);
      rdchk(`LSO_ADDR_ON_VALUE, 32'h0, `LSO_RESP_OKAY);
      rdchk(`LSO_ADDR_OFF_VALUE, 32'h0, `LSO_RESP_OKAY);
      rdchk(`LSO_ADDR_ON_DELAY, 32'h0, `LSO_RESP_OKAY);
      rdchk(`LSO_ADDR_OFF_DELAY, 32'h0, `LSO_RESP_OKAY);
      rdchk(8'h40, 32'h0, `LSO_RESP_SLVERR);
      wr(8'h40, 32'h1);
      chk({30'h0, bResp}, {30'h0, `LSO_RESP_SLVERR});
      // answers kept waiting by a late ready must stand
      lateRdy = 3;
      wr(`LSO_ADDR_OFF_DELAY, 32'h5);
      rdchk(`LSO_ADDR_OFF_DELAY, 32'h5, `LSO_RESP_OKAY);
      lateRdy = 0;
      wr(`LSO_ADDR_OFF_DELAY, 32'h0);
      $display("reset test done");
   endtask
   // on above off: 2.0 / 1.0
   task automatic testAbove();
      meas(32'h3FC00000, 2);
      wr(`LSO_ADDR_ON_VALUE, 32'h40000000);
      wr(`LSO_ADDR_OFF_VALUE, 32'h3F800000);
      wr(`LSO_ADDR_CTRL, 32'h0B);
      idle(6);
      outIs(1'b1);
      meas(32'h3F000000, 6);
      outIs(1'b0);
      meas(32'h3FC00000, 6);
      outIs(1'b0);
      meas(32'h40400000, 6);
      outIs(1'b1);
      $display("upper threshold test done");
   endtask
   // on below off: 1.0 / 2.0, with a negative value
   task automatic testBelow();
      wr(`LSO_ADDR_ON_VALUE, 32'h3F800000);
      wr(`LSO_ADDR_OFF_VALUE, 32'h40000000);
      idle(6);
      outIs(1'b0);
      meas(32'h3FC00000, 6);
      outIs(1'b0);
      meas(32'hBF800000, 6);
      outIs(1'b1);
      meas(32'h40400000, 6);
      outIs(1'b0);
      $display("lower threshold test done");
   endtask
   // delays of 2 and 3 tenths, a cancelled release, clamping
   task automatic testDelay();
      wr(`LSO_ADDR_ON_VALUE, 32'h40000000);
      wr(`LSO_ADDR_OFF_VALUE, 32'h3F800000);
      meas(32'h3F000000, 6);
      wr(`LSO_ADDR_ON_DELAY, 32'h2);
      wr(`LSO_ADDR_OFF_DELAY, 32'h3);
      meas(32'h40400000, 6);
      outIs(1'b0);
      idle(20);
      outIs(1'b1);
      meas(32'h3F000000, 6);
      meas(32'h3FC00000, 30);
      outIs(1'b1);
      meas(32'h3F000000, 6);
      outIs(1'b1);
      idle(30);
      outIs(1'b0);
      wr(`LSO_ADDR_ON_DELAY, 32'h7D0);
      rdchk(`LSO_ADDR_ON_DELAY, 32'h3E8, `LSO_RESP_OKAY);
      wr(`LSO_ADDR_ON_DELAY, 32'h0);
      wr(`LSO_ADDR_OFF_DELAY, 32'h0);
      $display("delay test done");
   endtask
   // failure modes on the digital function; inversion on the digital and off functions
   task automatic testFail();
      wr(`LSO_ADDR_CTRL, 32'h0C);
      digitalIn <= 1'b1;
      idle(4);
      outIs(1'b1);
      errorPresent <= 1'b1;
      idle(4);
      outIs(1'b0);
      digitalIn <= 1'b0;
      wr(`LSO_ADDR_CTRL, 32'h14);
      idle(4);
      outIs(1'b1);
      wr(`LSO_ADDR_CTRL, 32'h04);
      digitalIn <= 1'b1;
      idle(4);
      outIs(1'b1);
      errorPresent <= 1'b0;
      digitalIn <= 1'b0;
      wr(`LSO_ADDR_CTRL, 32'h24);
      idle(4);
      outIs(1'b1);
      wr(`LSO_ADDR_CTRL, 32'h20);
      idle(4);
      outIs(1'b1);
      $display("failure test done");
   endtask
   // every event class against every event kind
   task automatic testDiag();
      for (int c = 0; c < 3; c++) begin
         wr(`LSO_ADDR_CTRL, {24'h00, c[1:0], 6'h02});
         for (int e = 0; e < 3; e++) begin
            alarmEvent <= (e == 1);
            warningEvent <= (e == 2);
            idle(4);
            outIs(!((e == 1 && c != 2) || (e == 2 && c != 0)));
         end
      end
      warningEvent <= 1'b0;
      $display("diagnostic test done");
   endtask
   // raise, clear and mask the interrupt; status readback
   task automatic testIrq();
      wr(`LSO_ADDR_CTRL, 32'h00);
      wr(`LSO_ADDR_INT_CLR, 32'h7);
      wr(`LSO_ADDR_INT_EN, 32'h1);
      wr(`LSO_ADDR_CTRL, 32'h01);
      idle(4);
      chk({31'h0, irq}, 32'h1);
      rdchk(`LSO_ADDR_INT_STAT, 32'h1, `LSO_RESP_OKAY);
      rdchk(`LSO_ADDR_STATUS, 32'h1, `LSO_RESP_OKAY);
      wr(`LSO_ADDR_INT_CLR, 32'h1);
      chk({31'h0, irq}, 32'h0);
      wr(`LSO_ADDR_INT_EN, 32'h0);
      wr(`LSO_ADDR_CTRL, 32'h00);
      idle(4);
      chk({31'h0, irq}, 32'h0);
      rdchk(`LSO_ADDR_INT_STAT, 32'h2, `LSO_RESP_OKAY);
      wr(`LSO_ADDR_STATUS, 32'hFF);
      rdchk(`LSO_ADDR_STATUS, 32'h0, `LSO_RESP_OKAY);
      $display("interrupt test done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hang guard
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         $display("mismatch at %0t: run too long", $time);
         tally_and_finish();
      end
   end

   initial begin
      arst_n = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, measValue} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {errorPresent, alarmEvent, warningEvent, digitalIn} = '0;
      s_axi_wstrb = 4'hF;
      idle(8);
      arst_n <= 1'b1;
      idle(3);
      outIs(1'b0);
      testReset();
      testAbove();
      testBelow();
      testDelay();
      testFail();
      testDiag();
      testIrq();
      tally_and_finish();
   end
endmodule

bind lso_switch_output lso_checker u_lso_checker (.*);
`default_nettype wire
